// File: common/dual_counter_pkg.sv
package dual_counter_pkg;

  // ----------------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------------
  localparam int CNT_W          = 32;
  localparam int SRC_W          = 5;
  localparam int NUM_SRC        = 19;
  localparam int NUM_CNT        = 2;
  localparam int IRQ_W          = 4;
  localparam int CLK_PERIOD_NS  = 20;
  localparam int TICK_PERIOD_NS = 1000;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Event source codes
  // ----------------------------------------------------------------------
  localparam logic [SRC_W-1:0] SRC_OFF          = 5'h00;
  localparam logic [SRC_W-1:0] SRC_TICK         = 5'h01;
  localparam logic [SRC_W-1:0] SRC_LINE_BASE    = 5'h02;
  localparam logic [SRC_W-1:0] SRC_SWOUT_BASE   = 5'h06;
  localparam logic [SRC_W-1:0] SRC_BEGIN_BASE   = 5'h0a;
  localparam logic [SRC_W-1:0] SRC_FINISH_BASE  = 5'h0c;
  localparam logic [SRC_W-1:0] SRC_LOGIC_BASE   = 5'h0e;
  localparam logic [SRC_W-1:0] SRC_INTEG_BEGIN  = 5'h10;
  localparam logic [SRC_W-1:0] SRC_INTEG_FINISH = 5'h11;
  localparam logic [SRC_W-1:0] SRC_AWAIT_TRIG   = 5'h12;

  typedef enum logic [2:0] {
    QUAL_LEVEL_LOW  = 3'h0,
    QUAL_LEVEL_HIGH = 3'h1,
    QUAL_FALLING    = 3'h2,
    QUAL_RISING     = 3'h3,
    QUAL_ANY_EDGE   = 3'h4
  } qual_t;

  typedef enum logic [4:0] {
    ST_IDLE      = 5'h01,
    ST_TRIG_WAIT = 5'h02,
    ST_ACTIVE    = 5'h04,
    ST_COMPLETED = 5'h08,
    ST_OVERFLOW  = 5'h10
  } count_state_t;

  typedef struct packed {
    logic [SRC_W-1:0] count_source_select;
    qual_t            count_source_qualifier;
    logic [CNT_W-1:0] start_delay_count;
    logic [CNT_W-1:0] end_duration_count;
    logic [SRC_W-1:0] start_trigger_select;
    qual_t            start_trigger_qualifier;
    logic [SRC_W-1:0] reset_source_select;
    qual_t            reset_source_qualifier;
  } cfg_t;

  typedef struct packed {
    logic [CNT_W-1:0] live_count;
    logic [CNT_W-1:0] captured_count_on_reset;
    count_state_t     count_state;
    logic             begin_evt;
    logic             finish_evt;
  } stat_t;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_SELECT   = 8'h00;
  localparam logic [7:0] ADDR_CNT_SRC  = 8'h04;
  localparam logic [7:0] ADDR_CNT_QUAL = 8'h08;
  localparam logic [7:0] ADDR_DELAY    = 8'h0c;
  localparam logic [7:0] ADDR_DURATION = 8'h10;
  localparam logic [7:0] ADDR_TRG_SRC  = 8'h14;
  localparam logic [7:0] ADDR_TRG_QUAL = 8'h18;
  localparam logic [7:0] ADDR_RST_SRC  = 8'h1c;
  localparam logic [7:0] ADDR_RST_QUAL = 8'h20;
  localparam logic [7:0] ADDR_LIVE     = 8'h24;
  localparam logic [7:0] ADDR_CAPTURED = 8'h28;
  localparam logic [7:0] ADDR_STATE    = 8'h2c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h30;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h34;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Decides whether the selected source qualifies in this cycle.
  function automatic logic qualify(input logic [NUM_SRC-1:0] cur, input logic [NUM_SRC-1:0] prev,
                                   input logic [SRC_W-1:0] sel, input qual_t q);
    logic c;
    logic p;
    c = 1'b0;
    p = 1'b0;
    if (sel != SRC_OFF && sel < SRC_W'(NUM_SRC)) begin
      c = cur[sel];
      p = prev[sel];
    end
    case (q)
      QUAL_LEVEL_LOW:  qualify = (sel != SRC_OFF) && (sel < SRC_W'(NUM_SRC)) && !c;
      QUAL_LEVEL_HIGH: qualify = c;
      QUAL_FALLING:    qualify = p && !c;
      QUAL_RISING:     qualify = c && !p;
      QUAL_ANY_EDGE:   qualify = c ^ p;
      default:         qualify = 1'b0;
    endcase
  endfunction

endpackage

// File: hw/tick_divider.sv
`timescale 1ns/1ps
module tick_divider
  import dual_counter_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  // Tick
  output logic      tick_o
);

  localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);

  logic [7:0] div_q;
  logic [7:0] div_d;
  logic       tick_q;
  logic       tick_d;

  always_comb begin
    tick_d = (div_q == TICK_LAST);
    div_d  = tick_d ? '0 : div_q + 8'h01;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;

endmodule

// File: hw/counter_unit.sv
`timescale 1ns/1ps
module counter_unit
  import dual_counter_pkg::*;
(
  // Clock and reset
  input  wire logic               clk_sys_i,
  input  wire logic               rst_i,
  // Configuration and sources
  input  wire cfg_t               cfg_i,
  input  wire logic [NUM_SRC-1:0] src_i,
  input  wire logic [NUM_SRC-1:0] src_prev_i,
  // Status
  output stat_t                   stat_o
);

  count_state_t     state_q, state_d;
  logic [CNT_W-1:0] count_q, count_d;
  logic [CNT_W-1:0] capt_q, capt_d;
  logic             dur_phase_q, dur_phase_d;
  logic             begin_q, begin_d;
  logic             finish_q, finish_d;
  logic             cnt_ev, trg_ev, rst_ev, src_off;

  always_comb begin
    cnt_ev      = qualify(src_i, src_prev_i, cfg_i.count_source_select, cfg_i.count_source_qualifier);
    trg_ev      = qualify(src_i, src_prev_i, cfg_i.start_trigger_select, cfg_i.start_trigger_qualifier);
    rst_ev      = qualify(src_i, src_prev_i, cfg_i.reset_source_select, cfg_i.reset_source_qualifier);
    src_off     = (cfg_i.count_source_select == SRC_OFF);
    state_d     = state_q;
    count_d     = count_q;
    capt_d      = capt_q;
    dur_phase_d = dur_phase_q;
    begin_d     = 1'b0;
    finish_d    = 1'b0;
    if (src_off) begin
      state_d = ST_IDLE;
    end else if (rst_ev && state_q != ST_IDLE) begin
      capt_d      = count_q;
      count_d     = '0;
      dur_phase_d = 1'b0;
      state_d     = ST_ACTIVE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          count_d     = '0;
          dur_phase_d = 1'b0;
          state_d     = (cfg_i.start_trigger_select != SRC_OFF) ? ST_TRIG_WAIT : ST_ACTIVE;
        end
        ST_TRIG_WAIT, ST_COMPLETED: begin
          if (trg_ev) begin
            count_d     = '0;
            dur_phase_d = 1'b0;
            state_d     = ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          if (!dur_phase_q && count_q == cfg_i.start_delay_count) begin
            begin_d     = 1'b1;
            dur_phase_d = 1'b1;
            count_d     = '0;
          end else if (dur_phase_q && count_q == cfg_i.end_duration_count) begin
            finish_d = 1'b1;
            state_d  = ST_COMPLETED;
          end else if (cnt_ev) begin
            if (&count_q) begin
              state_d = ST_OVERFLOW;
            end else begin
              count_d = count_q + 1'b1;
            end
          end
        end
        ST_OVERFLOW: begin
          if (trg_ev) begin
            count_d     = '0;
            dur_phase_d = 1'b0;
            state_d     = ST_ACTIVE;
          end
        end
        default: state_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_q     <= ST_IDLE;
      count_q     <= '0;
      capt_q      <= '0;
      dur_phase_q <= 1'b0;
      begin_q     <= 1'b0;
      finish_q    <= 1'b0;
    end else begin
      state_q     <= state_d;
      count_q     <= count_d;
      capt_q      <= capt_d;
      dur_phase_q <= dur_phase_d;
      begin_q     <= begin_d;
      finish_q    <= finish_d;
    end
  end

  assign stat_o = '{live_count: count_q, captured_count_on_reset: capt_q, count_state: state_q,
                    begin_evt: begin_q, finish_evt: finish_q};

endmodule

// File: hw/dual_event_counter_timer.sv
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module dual_event_counter_timer
  import dual_counter_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // Event sources
  input  wire logic [3:0]  input_line_i,
  input  wire logic [3:0]  software_output_i,
  input  wire logic [1:0]  logic_unit_output_i,
  input  wire logic        sensor_integration_begin_i,
  input  wire logic        sensor_integration_finish_i,
  input  wire logic        awaiting_frame_trigger_i,
  // Counter events and interrupt
  output logic [1:0]       count_begin_event_o,
  output logic [1:0]       count_finish_event_o,
  output logic             irq_o
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  cfg_t               cfg_q [NUM_CNT];
  cfg_t               cfg_d [NUM_CNT];
  stat_t              stat [NUM_CNT];
  logic               sel_q, sel_d;
  logic [IRQ_W-1:0]   irq_stat_q, irq_stat_d;
  logic [IRQ_W-1:0]   irq_mask_q, irq_mask_d;
  logic [IRQ_W-1:0]   irq_set;
  logic               aw_have_q, aw_have_d;
  logic               w_have_q, w_have_d;
  logic [7:0]         awaddr_q, awaddr_d;
  logic [31:0]        wdata_q, wdata_d;
  logic [3:0]         wstrb_q, wstrb_d;
  logic               bvalid_q, bvalid_d;
  logic [1:0]         bresp_q, bresp_d;
  logic               rvalid_q, rvalid_d;
  logic [1:0]         rresp_q, rresp_d;
  logic [31:0]        rdata_q, rdata_d;
  logic               do_write, do_read;
  logic               tick;
  logic [NUM_SRC-1:0] src_vec, src_prev_q;
  logic [1:0]         begin_vec, finish_vec;

  // Merges byte lanes of a write into an existing register view.
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Reports whether an address hits a mapped register.
  function automatic logic addr_hit(input logic [7:0] a);
    case (a)
      ADDR_SELECT, ADDR_CNT_SRC, ADDR_CNT_QUAL, ADDR_DELAY, ADDR_DURATION, ADDR_TRG_SRC, ADDR_TRG_QUAL,
      ADDR_RST_SRC, ADDR_RST_QUAL, ADDR_LIVE, ADDR_CAPTURED, ADDR_STATE, ADDR_IRQ_STAT,
      ADDR_IRQ_MASK: addr_hit = 1'b1;
      default:       addr_hit = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Sources and counters
  // ----------------------------------------------------------------------
  tick_divider u_tick (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .tick_o    (tick)
  );

  assign src_vec = {awaiting_frame_trigger_i, sensor_integration_finish_i, sensor_integration_begin_i,
                    logic_unit_output_i, finish_vec, begin_vec, software_output_i, input_line_i,
                    tick, 1'b0};

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      src_prev_q <= '0;
    end else begin
      src_prev_q <= src_vec;
    end
  end

  generate
    for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
      counter_unit u_cnt (
        .clk_sys_i  (clk_sys_i),
        .rst_i      (rst_i),
        .cfg_i      (cfg_q[i]),
        .src_i      (src_vec),
        .src_prev_i (src_prev_q),
        .stat_o     (stat[i])
      );
      assign begin_vec[i]  = stat[i].begin_evt;
      assign finish_vec[i] = stat[i].finish_evt;
    end
  endgenerate

  assign count_begin_event_o  = begin_vec;
  assign count_finish_event_o = finish_vec;

  // ----------------------------------------------------------------------
  // Bus slave and register file
  // ----------------------------------------------------------------------
  assign s_axi_awready_o = !aw_have_q && !bvalid_q;
  assign s_axi_wready_o  = !w_have_q && !bvalid_q;
  assign s_axi_arready_o = !rvalid_q;
  assign do_write        = aw_have_q && w_have_q && !bvalid_q;
  assign do_read         = s_axi_arvalid_i && !rvalid_q;
  assign irq_set         = {finish_vec, begin_vec};

  always_comb begin
    logic [31:0] v;
    v          = '0;
    aw_have_d  = aw_have_q;
    w_have_d   = w_have_q;
    awaddr_d   = awaddr_q;
    wdata_d    = wdata_q;
    wstrb_d    = wstrb_q;
    bvalid_d   = bvalid_q;
    bresp_d    = bresp_q;
    rvalid_d   = rvalid_q;
    rresp_d    = rresp_q;
    rdata_d    = rdata_q;
    sel_d      = sel_q;
    cfg_d      = cfg_q;
    irq_mask_d = irq_mask_q;
    irq_stat_d = irq_stat_q;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_have_d = 1'b1;
      awaddr_d  = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_have_d = 1'b1;
      wdata_d  = s_axi_wdata_i;
      wstrb_d  = s_axi_wstrb_i;
    end
    if (do_write) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = addr_hit(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      case (awaddr_q)
        ADDR_SELECT: begin
          v     = wmerge({31'h0, sel_q}, wdata_q, wstrb_q);
          sel_d = v[0];
        end
        ADDR_CNT_SRC: begin
          v = wmerge(32'(cfg_q[sel_q].count_source_select), wdata_q, wstrb_q);
          cfg_d[sel_q].count_source_select = v[SRC_W-1:0];
        end
        ADDR_CNT_QUAL: begin
          v = wmerge(32'(cfg_q[sel_q].count_source_qualifier), wdata_q, wstrb_q);
          cfg_d[sel_q].count_source_qualifier = qual_t'(v[2:0]);
        end
        ADDR_DELAY: begin
          cfg_d[sel_q].start_delay_count = wmerge(cfg_q[sel_q].start_delay_count, wdata_q, wstrb_q);
        end
        ADDR_DURATION: begin
          cfg_d[sel_q].end_duration_count = wmerge(cfg_q[sel_q].end_duration_count, wdata_q, wstrb_q);
        end
        ADDR_TRG_SRC: begin
          v = wmerge(32'(cfg_q[sel_q].start_trigger_select), wdata_q, wstrb_q);
          cfg_d[sel_q].start_trigger_select = v[SRC_W-1:0];
          if (v[SRC_W-1:0] != SRC_OFF) begin
            cfg_d[sel_q].reset_source_select = SRC_OFF;
          end
        end
        ADDR_TRG_QUAL: begin
          v = wmerge(32'(cfg_q[sel_q].start_trigger_qualifier), wdata_q, wstrb_q);
          cfg_d[sel_q].start_trigger_qualifier = qual_t'(v[2:0]);
        end
        ADDR_RST_SRC: begin
          v = wmerge(32'(cfg_q[sel_q].reset_source_select), wdata_q, wstrb_q);
          cfg_d[sel_q].reset_source_select = v[SRC_W-1:0];
          if (v[SRC_W-1:0] != SRC_OFF) begin
            cfg_d[sel_q].start_trigger_select = SRC_OFF;
          end
        end
        ADDR_RST_QUAL: begin
          v = wmerge(32'(cfg_q[sel_q].reset_source_qualifier), wdata_q, wstrb_q);
          cfg_d[sel_q].reset_source_qualifier = qual_t'(v[2:0]);
        end
        ADDR_IRQ_MASK: begin
          v          = wmerge(32'(irq_mask_q), wdata_q, wstrb_q);
          irq_mask_d = v[IRQ_W-1:0];
        end
        default: begin
          v = '0;
        end
      endcase
    end
    if (bvalid_q && s_axi_bready_i) begin
      bvalid_d = 1'b0;
    end
    if (do_read) begin
      rvalid_d = 1'b1;
      rresp_d  = addr_hit(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr_i)
        ADDR_SELECT:   rdata_d = 32'(sel_q);
        ADDR_CNT_SRC:  rdata_d = 32'(cfg_q[sel_q].count_source_select);
        ADDR_CNT_QUAL: rdata_d = 32'(cfg_q[sel_q].count_source_qualifier);
        ADDR_DELAY:    rdata_d = cfg_q[sel_q].start_delay_count;
        ADDR_DURATION: rdata_d = cfg_q[sel_q].end_duration_count;
        ADDR_TRG_SRC:  rdata_d = 32'(cfg_q[sel_q].start_trigger_select);
        ADDR_TRG_QUAL: rdata_d = 32'(cfg_q[sel_q].start_trigger_qualifier);
        ADDR_RST_SRC:  rdata_d = 32'(cfg_q[sel_q].reset_source_select);
        ADDR_RST_QUAL: rdata_d = 32'(cfg_q[sel_q].reset_source_qualifier);
        ADDR_LIVE:     rdata_d = stat[sel_q].live_count;
        ADDR_CAPTURED: rdata_d = stat[sel_q].captured_count_on_reset;
        ADDR_STATE:    rdata_d = 32'(stat[sel_q].count_state);
        ADDR_IRQ_STAT: rdata_d = 32'(irq_stat_q);
        ADDR_IRQ_MASK: rdata_d = 32'(irq_mask_q);
        default:       rdata_d = '0;
      endcase
      if (s_axi_araddr_i == ADDR_IRQ_STAT) begin
        irq_stat_d = '0;
      end
    end
    if (rvalid_q && s_axi_rready_i) begin
      rvalid_d = 1'b0;
    end
    irq_stat_d = irq_stat_d | irq_set;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      aw_have_q  <= 1'b0;
      w_have_q   <= 1'b0;
      awaddr_q   <= '0;
      wdata_q    <= '0;
      wstrb_q    <= '0;
      bvalid_q   <= 1'b0;
      bresp_q    <= RESP_OKAY;
      rvalid_q   <= 1'b0;
      rresp_q    <= RESP_OKAY;
      rdata_q    <= '0;
      sel_q      <= 1'b0;
      cfg_q      <= '{default: '0};
      irq_mask_q <= '0;
      irq_stat_q <= '0;
    end else begin
      aw_have_q  <= aw_have_d;
      w_have_q   <= w_have_d;
      awaddr_q   <= awaddr_d;
      wdata_q    <= wdata_d;
      wstrb_q    <= wstrb_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      rvalid_q   <= rvalid_d;
      rresp_q    <= rresp_d;
      rdata_q    <= rdata_d;
      sel_q      <= sel_d;
      cfg_q      <= cfg_d;
      irq_mask_q <= irq_mask_d;
      irq_stat_q <= irq_stat_d;
    end
  end

  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o  = bresp_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rresp_o  = rresp_q;
  assign s_axi_rdata_o  = rdata_q;
  assign irq_o          = |(irq_stat_q & irq_mask_q);

endmodule

// File: tb/dual_event_counter_timer_properties.sv
`timescale 1ns/1ps
module dual_event_counter_timer_properties
  import dual_counter_pkg::*;
(
  // Watched ports
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic [1:0]  count_begin_event_o,
  input wire logic [1:0]  count_finish_event_o
);
  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence wr_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence rd_taken;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  wr_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid_o) else $error("no write response");
  rd_answer_a: assert property (rd_taken |=> s_axi_rvalid_o) else $error("no read data");
  b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped");
  ar_block_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o) else $error("read taken while busy");
  aw_block_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while busy");
  err_zero_a: assert property (
    s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR |-> s_axi_rdata_o == 32'h0)
    else $error("error read not zero");
  begin_pulse_a: assert property (count_begin_event_o[0] |=> !count_begin_event_o[0])
    else $error("begin pulse too long");
  finish_pulse_a: assert property (count_finish_event_o[0] |=> !count_finish_event_o[0])
    else $error("finish pulse too long");
endmodule

bind dual_event_counter_timer dual_event_counter_timer_properties u_dual_event_counter_timer_properties (
  .clk_sys_i, .rst_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
  .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
  .s_axi_rvalid_o, .s_axi_rready_i, .count_begin_event_o, .count_finish_event_o);

// File: tb/dual_event_counter_timer_tb.sv
`timescale 1ns/1ps
module dual_event_counter_timer_tb;
  import dual_counter_pkg::*;
  logic        clk_sys_i, rst_i, awv, wv, br, arv, rr, awr, wr_r, bv, arr, rv, integ, irq;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdat, d, a0;
  logic [1:0]  bresp, rresp, r, evb, evf;
  logic [3:0]  line;
  int          mismatches, n_compared, n_ev;
  int          exp_d [5] = '{4, 4, 1, 1, 2};

  always @(posedge clk_sys_i) n_ev <= n_ev + int'(evb[0]) + int'(evf[0]);

  dual_event_counter_timer u_dual_event_counter_timer (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_r),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br), .s_axi_araddr_i(ara),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .input_line_i(line), .software_output_i(4'h0),
    .logic_unit_output_i(2'h0), .sensor_integration_begin_i(integ), .sensor_integration_finish_i(1'b0),
    .awaiting_frame_trigger_i(1'b0), .count_begin_event_o(evb), .count_finish_event_o(evf), .irq_o(irq));

  // ----------------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, gb;
    ta = 0;
    tw = 0;
    gb = 0;
    @(posedge clk_sys_i);
    awa <= a;
    wd <= v;
    awv <= 1;
    wv <= 1;
    br <= 1;
    while (!(ta && tw)) begin
      @(negedge clk_sys_i);
      ta = ta | (awv & awr);
      tw = tw | (wv & wr_r);
      @(posedge clk_sys_i);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
    end
    while (!gb) begin
      @(negedge clk_sys_i);
      gb = bv;
      r = bresp;
      @(posedge clk_sys_i);
    end
    br <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic t;
    t = 0;
    @(posedge clk_sys_i);
    ara <= a;
    arv <= 1;
    rr <= 1;
    while (!t) begin
      @(negedge clk_sys_i);
      t = arr;
      @(posedge clk_sys_i);
    end
    arv <= 0;
    t = 0;
    while (!t) begin
      @(negedge clk_sys_i);
      t = rv;
      v = rdat;
      rs = rresp;
      @(posedge clk_sys_i);
    end
    rr <= 0;
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    rd(a, d, r);
    cmp(nm, e, d);
  endtask
  task automatic pulse(input int b, input int n);
    @(posedge clk_sys_i);
    line[b] <= ~line[b];
    tick(n);
    line[b] <= ~line[b];
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    clk_sys_i = 0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #400000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    {rst_i, awv, wv, br, arv, rr, integ} = 7'b1000000;
    {awa, ara, wd, line} = '0;
    tick(12);
    rst_i <= 0;
    chk(ADDR_STATE, 32'(ST_IDLE), "reset state");
    rd(8'h3c, d, r);
    cmp("unmapped resp", 32'(RESP_SLVERR), {30'h0, r});
    wr(8'h3c, 32'h1);
    cmp("unmapped wresp", 32'(RESP_SLVERR), {30'h0, r});
    wr(ADDR_LIVE, 32'h1234);
    wr(ADDR_STATE, 32'hff);
    cmp("ro wresp", 32'(RESP_OKAY), {30'h0, r});
    chk(ADDR_LIVE, 32'h0, "live write");
    chk(ADDR_STATE, 32'(ST_IDLE), "state write");
    wr(ADDR_IRQ_MASK, 32'hf);
    wr(ADDR_DELAY, 32'h2);
    wr(ADDR_DURATION, 32'h1);
    wr(ADDR_CNT_QUAL, 32'h3);
    wr(ADDR_CNT_SRC, 32'(SRC_LINE_BASE));
    chk(ADDR_STATE, 32'(ST_ACTIVE), "run state");
    pulse(0, 2);
    pulse(0, 2);
    tick(3);
    chk(ADDR_LIVE, 32'h0, "after delay");
    chk(ADDR_IRQ_STAT, 32'h1, "begin irq");
    pulse(0, 2);
    tick(3);
    cmp("irq set", 32'h1, {31'h0, irq});
    pulse(0, 2);
    tick(3);
    chk(ADDR_LIVE, 32'h1, "held count");
    chk(ADDR_STATE, 32'(ST_COMPLETED), "done state");
    cmp("counter0 events", 32'h2, 32'(n_ev));
    chk(ADDR_IRQ_STAT, 32'h4, "irq status");
    cmp("irq clear", 32'h0, {31'h0, irq});
    wr(ADDR_TRG_QUAL, 32'h3);
    wr(ADDR_TRG_SRC, 32'(SRC_INTEG_BEGIN));
    @(posedge clk_sys_i);
    integ <= 1;
    tick(2);
    integ <= 0;
    chk(ADDR_STATE, 32'(ST_ACTIVE), "retrigger");
    wr(ADDR_SELECT, 32'h1);
    chk(ADDR_CNT_SRC, 32'h0, "second source");
    wr(ADDR_TRG_QUAL, 32'h3);
    wr(ADDR_TRG_SRC, 32'h5);
    wr(ADDR_RST_QUAL, 32'h3);
    wr(ADDR_RST_SRC, 32'h4);
    chk(ADDR_TRG_SRC, 32'h0, "trigger off");
    wr(ADDR_DELAY, 32'hff);
    wr(ADDR_DURATION, 32'hff);
    wr(ADDR_CNT_SRC, 32'h3);
    for (int q = 0; q < 5; q++) begin
      @(posedge clk_sys_i);
      line[1] <= (q != 1);
      tick(2);
      wr(ADDR_CNT_QUAL, 32'(q));
      rd(ADDR_LIVE, a0, r);
      pulse(1, 4);
      tick(3);
      rd(ADDR_LIVE, d, r);
      cmp("qualified count", 32'(exp_d[q]), d - a0);
    end
    pulse(2, 2);
    pulse(1, 4);
    tick(2);
    pulse(2, 2);
    tick(3);
    chk(ADDR_CAPTURED, 32'h2, "captured");
    chk(ADDR_LIVE, 32'h0, "cleared");
    wr(ADDR_CNT_SRC, 32'(SRC_OFF));
    chk(ADDR_STATE, 32'(ST_IDLE), "source off");
    report_and_stop();
  end
endmodule
